// ### dv/looping_address_update_unit_tb.sv
// Self-checking bench for the looping address update unit.
module looping_address_update_unit_tb
    import loop_addr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [10:0] ctrl;
        loop_op_type op;
        logic [1:0]  b;
        logic        ds;
        logic [15:0] a, dp, c, y;
        logic        f;
        logic [15:0] r;
    } row_type;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, instr_valid, addr_valid, compare_zero_out;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seen_count, q;
    logic [15:0] data_port_in, addr_out, seen_addr;
    logic        data_port_select_in, e;
    instr_type   instr;
    int          miscompares = 0;
    int          n_tests = 0;
    row_type     rows [9];

    looping_address_update_unit dut (.core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr), .data_port_select_in(data_port_select_in),
        .data_port_in(data_port_in), .addr_out(addr_out), .addr_valid(addr_valid),
        .compare_zero_out(compare_zero_out));
    mem_addr_bus_model mem (.core_clk(core_clk), .reset(reset), .addr_out(addr_out), .addr_valid(addr_valid),
        .seen_addr(seen_addr), .seen_count(seen_count));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // The request is held until pready is sampled high, then released on that same edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_instr(input instr_type ins, input logic ds, input logic [15:0] dp);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr <= ins;
        data_port_select_in <= ds;
        data_port_in <= dp;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        data_port_select_in <= 1'b0;
        #1;
        check(addr_valid, 1);
    endtask : do_instr

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        finish_test();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, instr_valid, data_port_select_in, data_port_in} = '0;
        instr = '0;
        reset = 1'b1;
        rows[0] = '{11'h001, loop_increment_op, 2'h0, 1'b0, 16'h0010, 16'h0, 16'h0020, 16'h0010, 1'b0, 16'h0011};
        rows[1] = '{11'h201, loop_increment_op, 2'h0, 1'b0, 16'h001f, 16'h0, 16'h0020, 16'h0020, 1'b1, 16'h0100};
        rows[2] = '{11'h001, loop_add_offset_op, 2'h0, 1'b0, 16'hffff, 16'h0, 16'h0000, 16'hffff, 1'b1, 16'h0100};
        rows[3] = '{11'h201, loop_decrement_op, 2'h0, 1'b0, 16'h0001, 16'h0, 16'h0000, 16'h0000, 1'b1, 16'h0100};
        rows[4] = '{11'h001, loop_subtract_offset_op, 2'h0, 1'b0, 16'h0050, 16'h0, 16'h0040, 16'h0050, 1'b0, 16'h004c};
        rows[5] = '{11'h000, loop_increment_op, 2'h0, 1'b0, 16'h0030, 16'h0, 16'h0020, 16'h0030, 1'b1, 16'h0031};
        rows[6] = '{11'h601, loop_add_offset_op, 2'h0, 1'b0, 16'h001c, 16'h0, 16'h0020, 16'h0020, 1'b1, 16'h0020};
        rows[7] = '{11'h201, loop_subtract_offset_op, 2'h3, 1'b0, 16'h0010, 16'h3, 16'h0, 16'h000d, 1'b0, 16'h000d};
        rows[8] = '{11'h001, loop_increment_op, 2'h0, 1'b1, 16'h0010, 16'h44, 16'h0100, 16'h0044, 1'b0, 16'h0045};
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 8'h00, {21'h0, rows[i].ctrl});
            apb(1'b1, 8'h44, {16'h0, rows[i].a});
            apb(1'b1, 8'h80, 32'h4);
            apb(1'b1, 8'ha0, {16'h0, rows[i].c});
            apb(1'b1, 8'hb0, 32'h0100);
            do_instr('{rows[i].op, 4'h1, rows[i].b, 2'h0}, rows[i].ds, rows[i].dp);
            check(addr_out, rows[i].y);
            check(compare_zero_out, rows[i].f);
            apb(1'b0, 8'h44, 32'h0);
            check(q, rows[i].r);
            $display("row %0d done", i);
        end
        // An increase past the bound is not caught by a following decrease in pre-update mode.
        apb(1'b1, 8'h00, 32'h001);
        apb(1'b1, 8'h44, 32'h001e);
        apb(1'b1, 8'ha0, 32'h0020);
        do_instr('{loop_add_offset_op, 4'h1, 2'h0, 2'h0}, 1'b0, 16'h0);
        check(addr_out, 32'h001e);
        do_instr('{loop_decrement_op, 4'h1, 2'h0, 2'h0}, 1'b0, 16'h0);
        check(addr_out, 32'h0022);
        check(compare_zero_out, 0);
        apb(1'b0, 8'h44, 32'h0);
        check(q, 32'h0021);
        check(seen_count, 32'd11);
        check(seen_addr, 32'h0022);
        $display("overshoot test done");
        // Bank bits pick the upper address and offset registers for the offset ops.
        apb(1'b1, 8'h00, 32'h0180);
        apb(1'b1, 8'h64, 32'h0050);
        apb(1'b1, 8'h90, 32'h0002);
        do_instr('{loop_add_offset_op, 4'h1, 2'h0, 2'h0}, 1'b0, 16'h0);
        check(addr_out, 32'h0050);
        check(compare_zero_out, 1);
        apb(1'b0, 8'h64, 32'h0);
        check(q, 32'h0052);
        apb(1'b0, 8'h04, 32'h0);
        check(q, 32'h0001_0050);
        $display("bank test done");
        apb(1'b0, 8'h8c, 32'h0);
        check(e, 1);
        check(q, 0);
        $display("unmapped test done");
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        check({addr_out, compare_zero_out, addr_valid}, 0);
        apb(1'b0, 8'h00, 32'h0);
        check(q, 0);
        apb(1'b0, 8'h44, 32'h0);
        check(q, 0);
        $display("reset test done");
        finish_test();
    end
endmodule : looping_address_update_unit_tb

// ### dv/mem_addr_bus_model.sv
// Memory-side model that latches each strobed address and counts the strobes.
module mem_addr_bus_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [15:0] addr_out,
    input  wire logic        addr_valid,
    output logic      [15:0] seen_addr,
    output logic      [31:0] seen_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // The memory acts only on a strobed address, so the port value between strobes is ignored.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            seen_count <= 32'h0;
        end else if (addr_valid) begin
            seen_addr  <= addr_out;
            seen_count <= seen_count + 32'h1;
        end
    end
endmodule : mem_addr_bus_model

// ### rtl/loop_addr_consts.svh
// Offsets, field positions, reset values and sizes of the looping address update unit.
`ifndef LOOP_ADDR_CONSTS_SVH
`define LOOP_ADDR_CONSTS_SVH
`define ADDR_WIDTH          16
`define CTRL_WIDTH          11
`define CTRL_RESET          11'h000
`define CTRL_MASK_LSB       0
`define CTRL_MASK_MSB       3
`define CTRL_R_BANK_BIT     7
`define CTRL_B_BANK_BIT     8
`define CTRL_POST_BIT       9
`define CTRL_AIR_COND_BIT   10
`define NUM_ADDR_REGS       16
`define NUM_OFFSET_SLOTS    8
`define NUM_CMP_REGS        4
`define OFFSET_DATA_PORT    2'h3
`define REG_CONTROL_OFFSET  8'h00
`define REG_STATUS_OFFSET   8'h04
`define REG_ADDR_BASE       8'h40
`define REG_OFFSET_BASE     8'h80
`define REG_CMP_BASE        8'ha0
`define REG_INIT_BASE       8'hb0
`endif

// ### rtl/loop_addr_pkg.sv
// Types shared by the looping address update unit and its bench.
package loop_addr_pkg;
    typedef enum logic [1:0] {
        loop_increment_op,
        loop_add_offset_op,
        loop_decrement_op,
        loop_subtract_offset_op
    } loop_op_type;

    typedef struct packed {
        loop_op_type op;
        logic [3:0]  r_sel;
        logic [1:0]  b_sel;
        logic [1:0]  c_sel;
    } instr_type;

    typedef enum logic [2:0] {
        sel_none,
        sel_control,
        sel_status,
        sel_addr,
        sel_offset,
        sel_cmp,
        sel_init
    } reg_kind_type;

    typedef struct packed {
        reg_kind_type kind;
        logic [3:0]   idx;
    } reg_sel_type;
endpackage : loop_addr_pkg

// ### rtl/looping_address_update_unit.sv
// Looping address update unit with an APB register slave.
//
// The implementer's own choices: register access over APB and the address map.
`include "loop_addr_consts.svh"

// Operation
// - Pre-update emits the unmodified address, post-update emits the modified one.
// - Modified address is written back unless the instruction reloads the register.
// - Source address is the selected address register or the data port.
// - Modifications are add offset, subtract offset, add one, subtract one.
// - Boundary reached reloads the source register from the initialization register with the compare register's index.
// - Boundary compare is unsigned sixteen bit.
// - Increasing ops flag when emitted address is at or above the bound.
// - Decreasing ops flag when emitted address is at or below the bound.
// - Compare flag enables reload and drives the compare output pin.
// - Reload only when the matching reinitialization mask bit is set.
// - Mask bit clear always writes the modified address, ignoring the flag.
// - Post-update emits, tests and reloads in the same instruction.
// - Pre-update shows a modified address only on a later use of that register.
// - Pre-update tests a stored address only when a later instruction emits it.
// - Compare direction follows the emitting instruction, not the producing one.
// - Control bit nine set selects post-update, clear selects pre-update.
// - Conditional alternate-instruction mode suppresses every reload.
module looping_address_update_unit
    import loop_addr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        instr_valid,
    input  wire instr_type   instr,
    input  wire logic        data_port_select_in,
    input  wire logic [15:0] data_port_in,
    output logic      [15:0] addr_out,
    output logic             addr_valid,
    output logic             compare_zero_out
);
    logic [10:0] control_word_reg;
    logic [15:0] addr_reg   [`NUM_ADDR_REGS];
    logic [15:0] offset_reg [`NUM_OFFSET_SLOTS];
    logic [15:0] cmp_reg    [`NUM_CMP_REGS];
    logic [15:0] init_reg   [`NUM_CMP_REGS];

    logic [3:0]  r_idx;
    logic [2:0]  b_idx;
    logic [15:0] src_val;
    logic [15:0] off_val;
    logic [15:0] mod_val;
    logic [15:0] emit_val;
    logic [15:0] bound_val;
    logic        post_mode;
    logic        cmp_flag;
    logic        reload;
    reg_sel_type wsel;
    logic        apb_write;
    logic [31:0] read_next;
    logic        err_next;

    function automatic logic is_increasing(input loop_op_type op);
        return (op == loop_increment_op) || (op == loop_add_offset_op);
    endfunction : is_increasing

    // Offset slots 3 and 7 stand for the data port and hold no storage.
    function automatic reg_sel_type decode(input logic [7:0] a);
        reg_sel_type s;
        s.kind = sel_none;
        s.idx  = a[5:2];
        if (a[1:0] != 2'h0) begin
            s.kind = sel_none;
        end else if (a == `REG_CONTROL_OFFSET) begin
            s.kind = sel_control;
        end else if (a == `REG_STATUS_OFFSET) begin
            s.kind = sel_status;
        end else if (a[7:6] == `REG_ADDR_BASE >> 6) begin
            s.kind = sel_addr;
        end else if (a[7:5] == `REG_OFFSET_BASE >> 5) begin
            s.kind = (a[4:2] == 3'h3 || a[4:2] == 3'h7) ? sel_none : sel_offset;
        end else if (a[7:4] == `REG_CMP_BASE >> 4) begin
            s.kind = sel_cmp;
        end else if (a[7:4] == `REG_INIT_BASE >> 4) begin
            s.kind = sel_init;
        end
        return s;
    endfunction : decode

    // Bank bit applies only to the offset ops, which name one of eight registers.
    always_comb begin
        post_mode = control_word_reg[`CTRL_POST_BIT];
        r_idx     = instr.r_sel;
        if (instr.op == loop_add_offset_op || instr.op == loop_subtract_offset_op) begin
            r_idx = {control_word_reg[`CTRL_R_BANK_BIT], instr.r_sel[2:0]};
        end
        b_idx     = {control_word_reg[`CTRL_B_BANK_BIT], instr.b_sel};
        src_val   = data_port_select_in ? data_port_in : addr_reg[r_idx];
        off_val   = (instr.b_sel == `OFFSET_DATA_PORT) ? data_port_in : offset_reg[b_idx];
        case (instr.op)
            loop_add_offset_op:      mod_val = src_val + off_val;
            loop_subtract_offset_op: mod_val = src_val - off_val;
            loop_increment_op:       mod_val = src_val + 16'h0001;
            loop_decrement_op:       mod_val = src_val - 16'h0001;
            default:                 mod_val = src_val;
        endcase
        emit_val  = post_mode ? mod_val : src_val;
        bound_val = cmp_reg[instr.c_sel];
        // Only the emitted value is tested, so a pre-update result waits for its next use.
        if (is_increasing(instr.op)) begin
            cmp_flag = (emit_val >= bound_val);
        end else begin
            cmp_flag = (emit_val <= bound_val);
        end
        reload = cmp_flag && control_word_reg[instr.c_sel]
                 && !control_word_reg[`CTRL_AIR_COND_BIT];
    end

    always_comb begin
        wsel      = decode(paddr);
        apb_write = psel && penable && pready && pwrite && (wsel.kind != sel_none);
        read_next = 32'h0000_0000;
        err_next  = (wsel.kind == sel_none);
        case (wsel.kind)
            sel_control: read_next = {21'h000000, control_word_reg};
            sel_status:  read_next = {15'h0000, compare_zero_out, addr_out};
            sel_addr:    read_next = {16'h0000, addr_reg[wsel.idx]};
            sel_offset:  read_next = {16'h0000, offset_reg[wsel.idx[2:0]]};
            sel_cmp:     read_next = {16'h0000, cmp_reg[wsel.idx[1:0]]};
            sel_init:    read_next = {16'h0000, init_reg[wsel.idx[1:0]]};
            default:     read_next = 32'h0000_0000;
        endcase
    end

    // Answer is registered at the setup edge, so every access phase is one cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= (psel && !penable && !pwrite) ? read_next : 32'h0000_0000;
            pslverr <= psel && !penable && err_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            control_word_reg <= `CTRL_RESET;
        end else if (apb_write && wsel.kind == sel_control) begin
            control_word_reg <= pwdata[10:0];
        end
    end

    // An instruction beats a software write to any address register in the same cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int k = 0; k < `NUM_ADDR_REGS; k++) begin
                addr_reg[k] <= 16'h0000;
            end
        end else if (instr_valid) begin
            addr_reg[r_idx] <= reload ? init_reg[instr.c_sel] : mod_val;
        end else if (apb_write && wsel.kind == sel_addr) begin
            addr_reg[wsel.idx] <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int k = 0; k < `NUM_OFFSET_SLOTS; k++) begin
                offset_reg[k] <= 16'h0000;
            end
            for (int k = 0; k < `NUM_CMP_REGS; k++) begin
                cmp_reg[k]  <= 16'h0000;
                init_reg[k] <= 16'h0000;
            end
        end else if (apb_write) begin
            if (wsel.kind == sel_offset) begin
                offset_reg[wsel.idx[2:0]] <= pwdata[15:0];
            end
            if (wsel.kind == sel_cmp) begin
                cmp_reg[wsel.idx[1:0]] <= pwdata[15:0];
            end
            if (wsel.kind == sel_init) begin
                init_reg[wsel.idx[1:0]] <= pwdata[15:0];
            end
        end
    end

    // The flag pin holds the last looping result until the next instruction.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_out         <= 16'h0000;
            addr_valid       <= 1'b0;
            compare_zero_out <= 1'b0;
        end else begin
            addr_valid <= instr_valid;
            if (instr_valid) begin
                addr_out         <= emit_val;
                compare_zero_out <= cmp_flag;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_loop_cmd;
        instr_valid;
    endsequence
    sequence s_apb_setup;
        psel && !penable;
    endsequence
    sequence s_loop_up;
        instr_valid && is_increasing(instr.op);
    endsequence
    sequence s_loop_down;
        instr_valid && !is_increasing(instr.op);
    endsequence
    sequence s_ctrl_write;
        s_apb_setup ##1 (penable && pready && pwrite && paddr == `REG_CONTROL_OFFSET);
    endsequence

    property p_pre_emits_source;
        s_loop_cmd and !post_mode |=> addr_out == $past(src_val) && addr_valid;
    endproperty
    a_pre_emits_source: assert property (p_pre_emits_source) else $error("Pre-update emitted wrong address.");

    property p_post_emits_modified;
        s_loop_cmd and post_mode |=> addr_out == $past(mod_val) && addr_valid;
    endproperty
    a_post_emits_modified: assert property (p_post_emits_modified) else $error("Post-update emitted wrong address.");

    property p_data_port_select_in_source;
        s_loop_cmd and data_port_select_in and !post_mode |=> addr_out == $past(data_port_in);
    endproperty
    a_data_port_select_in_source: assert property (p_data_port_select_in_source) else $error("Data port not used as source.");

    property p_writeback;
        s_loop_cmd and !reload |=> addr_reg[$past(r_idx)] == $past(mod_val);
    endproperty
    a_writeback: assert property (p_writeback) else $error("Modified address not written back.");

    property p_reload;
        s_loop_cmd and reload |=> addr_reg[$past(r_idx)] == $past(init_reg[instr.c_sel]);
    endproperty
    a_reload: assert property (p_reload) else $error("Reload from init register missing.");

    property p_flag_up;
        s_loop_cmd and is_increasing(instr.op) |=> compare_zero_out == ($past(emit_val) >= $past(bound_val));
    endproperty
    a_flag_up: assert property (p_flag_up) else $error("Upper limit flag wrong.");

    property p_flag_down;
        s_loop_cmd and !is_increasing(instr.op) |=> compare_zero_out == ($past(emit_val) <= $past(bound_val));
    endproperty
    a_flag_down: assert property (p_flag_down) else $error("Lower limit flag wrong.");

    property p_mask_linear;
        s_loop_cmd and !control_word_reg[instr.c_sel] |=> addr_reg[$past(r_idx)] == $past(mod_val);
    endproperty
    a_mask_linear: assert property (p_mask_linear) else $error("Reload despite clear mask bit.");

    property p_air_no_reload;
        s_loop_cmd and control_word_reg[`CTRL_AIR_COND_BIT] |=> addr_reg[$past(r_idx)] == $past(mod_val);
    endproperty
    a_air_no_reload: assert property (p_air_no_reload) else $error("Reload in alternate mode.");

    property p_ctrl_write;
        s_ctrl_write |=> control_word_reg == $past(pwdata[10:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("Control word write lost.");

    property p_unsigned_top;
        s_loop_up and emit_val == 16'hffff |=> compare_zero_out;
    endproperty
    a_unsigned_top: assert property (p_unsigned_top) else $error("All-ones address missed the upper bound.");

    property p_unsigned_bottom;
        s_loop_down and emit_val == 16'h0000 |=> compare_zero_out;
    endproperty
    a_unsigned_bottom: assert property (p_unsigned_bottom) else $error("Zero address missed the lower bound.");

    property p_post_same_cycle;
        s_loop_up and post_mode and (mod_val >= cmp_reg[instr.c_sel]) and control_word_reg[instr.c_sel]
            and !control_word_reg[`CTRL_AIR_COND_BIT] |=> addr_reg[$past(r_idx)] == $past(init_reg[instr.c_sel]);
    endproperty
    a_post_same_cycle: assert property (p_post_same_cycle) else $error("Post-update reload missed.");

    property p_pre_stored;
        s_loop_cmd and !post_mode and !data_port_select_in |=> addr_out == $past(addr_reg[r_idx]);
    endproperty
    a_pre_stored: assert property (p_pre_stored) else $error("Pre-update did not emit the stored address.");

    property p_outputs_stand;
        !instr_valid |=> $stable(addr_out) && $stable(compare_zero_out) && !addr_valid;
    endproperty
    a_outputs_stand: assert property (p_outputs_stand) else $error("Address outputs moved without an instruction.");

    property p_linear_below;
        s_loop_up and (emit_val < cmp_reg[instr.c_sel]) |=> addr_reg[$past(r_idx)] == $past(mod_val);
    endproperty
    a_linear_below: assert property (p_linear_below) else $error("Reload below the upper bound.");

    property p_apb_answer;
        s_apb_setup ##1 penable |-> pready ##1 !pready || (psel && !penable);
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("APB answer timing wrong.");
endmodule : looping_address_update_unit
